// *** egl_pkg.sv ***
package egl_pkg;

  // clock and frame timing
  localparam int          CLK_PERIOD_NS   = 20;
  localparam longint      CLK_HZ          = 64'd1_000_000_000 / 64'(CLK_PERIOD_NS);
  localparam longint      FPS_SCALE       = 64'd100;           // frame rate in 1/100 fps
  localparam logic [33:0] FRAME_ACC_LIMIT = 34'(CLK_HZ * FPS_SCALE);
  localparam logic [31:0] FPS_RST         = 32'h0000_09C4;     // 25.00 fps -> 40 ms

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_FPS      = 8'h04;
  localparam logic [7:0] ADDR_EXP_MAN  = 8'h08;
  localparam logic [7:0] ADDR_GAIN_MAN = 8'h0C;
  localparam logic [7:0] ADDR_EXP_MIN  = 8'h10;
  localparam logic [7:0] ADDR_EXP_MAX  = 8'h14;
  localparam logic [7:0] ADDR_GAIN_MIN = 8'h18;
  localparam logic [7:0] ADDR_GAIN_MAX = 8'h1C;
  localparam logic [7:0] ADDR_TARGET   = 8'h20;
  localparam logic [7:0] ADDR_OFS_MAX  = 8'h24;
  localparam logic [7:0] ADDR_TAP_OFS  = 8'h28;
  localparam logic [7:0] ADDR_PERIOD   = 8'h2C;
  localparam logic [7:0] ADDR_EXP_CUR  = 8'h30;
  localparam logic [7:0] ADDR_GAIN_CUR = 8'h34;
  localparam logic [7:0] ADDR_AVG      = 8'h38;
  localparam logic [7:0] ADDR_BLACK    = 8'h3C;

  // control and tap-offset field positions
  localparam int CTRL_AUTO      = 0;
  localparam int CTRL_EXP_SRC   = 1;
  localparam int CTRL_DEPTH_LO  = 2;
  localparam int CTRL_GAIN_STEP = 4;
  localparam int TAP_SEL_LO     = 16;

  // pixel depth codes and mosaic colour codes
  localparam logic [1:0] DEPTH_8  = 2'h0;
  localparam logic [1:0] DEPTH_12 = 2'h1;
  localparam logic [1:0] DEPTH_16 = 2'h2;
  localparam logic [1:0] CFA_G    = 2'h0;
  localparam logic [1:0] CFA_R    = 2'h1;
  localparam logic [1:0] CFA_B    = 2'h2;

  // reset values (gain in 0.1 dB units, exposure in clock cycles)
  localparam logic [31:0] EXP_RST      = 32'h0000_4E20;
  localparam logic [31:0] EXP_MIN_RST  = 32'h0000_0032;
  localparam logic [31:0] EXP_MAX_RST  = 32'h001E_8480;
  localparam logic [7:0]  GAIN_RST     = 8'h00;
  localparam logic [7:0]  GAIN_MAX_RST = 8'hF0;
  localparam logic [15:0] TARGET_RST   = 16'h8000;
  localparam logic [15:0] OFS_MAX_RST  = 16'h0FFF;
  localparam logic [15:0] LUMA_TOL     = 16'h0100;
  localparam int          EXP_SHIFT    = 3;
  localparam int          BLK_SHIFT    = 4;

  // discrete gain steps: 0, 1.6, 2.9, 4.1, 6.0, 7.6, 8.9, 10.1 dB
  localparam int          GAIN_NSTEP = 8;
  localparam logic [7:0]  GAIN_STEP_TAB [GAIN_NSTEP] =
    '{8'h00, 8'h10, 8'h1D, 8'h29, 8'h3C, 8'h4C, 8'h59, 8'h65};

  localparam int TAP_W = 2;

  typedef struct packed {
    logic             vld;
    logic             dark;
    logic [TAP_W-1:0] tap;
    logic [15:0]      data;
  } egl_pix_t;

  typedef struct packed {
    logic             vld;
    logic [TAP_W-1:0] tap;
    logic [1:0]       cfa;
    logic [15:0]      data;
  } egl_pix_out_t;

  typedef enum logic [2:0] {
    LS_IDLE = 3'b001,
    LS_DIV  = 3'b010,
    LS_ADJ  = 3'b100
  } egl_luma_st_t;

endpackage

// *** egl_tap_mem.sv ***
`timescale 1ns/10ps
module egl_tap_mem
  import egl_pkg::*;
#(
  parameter int DEPTH = 4,
  parameter int WIDTH = 16
) (
  // clock
  input  wire logic                     clk_sys,
  input  wire logic                     ce,
  // write port
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  // read port, one cycle latency
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [WIDTH-1:0]         rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // no reset on the array so it maps to plain storage
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule // egl_tap_mem

// *** egl_ctrl.sv ***
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module egl_ctrl
  import egl_pkg::*;
#(
  parameter int NTAPS = 4
) (
  // clock, reset, enable
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic         ce,
  // axi4-lite slave
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  // sensor side
  input  wire logic         sen_fval,
  input  wire logic         sen_lval,
  input  wire egl_pix_t     sen_pix,
  input  wire logic         trig_in,
  // settings to sensor and pixel output
  output logic [31:0]       exp_time,
  output logic [7:0]        gain_db10,
  output logic              frame_tick,
  output egl_pix_out_t      pix_out
);
  logic rst_q1, rst_q2;
  logic [31:0] ctrl, fps, exp_man, exp_min, exp_max, tap_ofs_last, period_meas, period_cnt;
  logic [7:0]  gain_man, gain_min, gain_max, gain_pend;
  logic [15:0] target, ofs_max, blk, avg, tap_rd;
  logic [33:0] frame_acc;
  logic [31:0] exp_pend, trig_cnt, trig_width;
  logic        trig_q, aw_held, w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [1:0]  fv_q;
  logic        lv_q, row_odd, col_odd, p1_act;
  logic [1:0]  p1_cfa;
  egl_pix_t    p1;
  logic [39:0] sum, div_num;
  logic [23:0] pix_cnt, div_den;
  logic [24:0] div_rem;
  logic [5:0]  div_step;
  egl_luma_st_t ls;
  logic        frame_start, frame_end, wr_fire, tap_we;
  logic [24:0] next_rem;
  logic [16:0] ofs_sum;
  logic [15:0] ofs_app, corr;

  // byte-lane merge for register writes
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      wmerge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  // next gain step up or down, table steps or 0.1 dB units
  function automatic logic [7:0] gain_move(input logic [7:0] g, input logic up,
                                           input logic stepped);
    gain_move = g;
    if (!stepped) begin
      gain_move = up ? g + 8'h01 : g - 8'h01;
    end else if (up) begin
      for (int i = GAIN_NSTEP - 1; i >= 0; i--) begin
        if (GAIN_STEP_TAB[i] > g) gain_move = GAIN_STEP_TAB[i];
      end
    end else begin
      for (int i = 0; i < GAIN_NSTEP; i++) begin
        if (GAIN_STEP_TAB[i] < g) gain_move = GAIN_STEP_TAB[i];
      end
    end
  endfunction

  // the rest of the design runs on the synchronised copy of the reset
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end

  assign frame_start = fv_q[0] & ~fv_q[1];
  assign frame_end   = ~fv_q[0] & fv_q[1];
  assign wr_fire     = aw_held & w_held & ~s_axi_bvalid;
  assign tap_we      = wr_fire & (aw_addr == ADDR_TAP_OFS);

  // write channel: address and data taken in either order, response after both
  always_ff @(posedge clk_sys or negedge rst_q2) begin
    if (!rst_q2) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // status words and holes answer slverr
        s_axi_bresp  <= (aw_addr[1:0] == 2'b00 && aw_addr <= ADDR_TAP_OFS) ? 2'b00 : 2'b10;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // software-writable settings
  always_ff @(posedge clk_sys or negedge rst_q2) begin
    if (!rst_q2) begin
      ctrl         <= 32'h0;
      fps          <= FPS_RST;
      exp_man      <= EXP_RST;
      gain_man     <= GAIN_RST;
      exp_min      <= EXP_MIN_RST;
      exp_max      <= EXP_MAX_RST;
      gain_min     <= GAIN_RST;
      gain_max     <= GAIN_MAX_RST;
      target       <= TARGET_RST;
      ofs_max      <= OFS_MAX_RST;
      tap_ofs_last <= 32'h0;
    end else if (ce && wr_fire) begin
      case (aw_addr)
        ADDR_CTRL:     ctrl <= wmerge(ctrl, w_data, w_strb);
        ADDR_FPS:      fps <= wmerge(fps, w_data, w_strb);
        ADDR_EXP_MAN:  exp_man <= wmerge(exp_man, w_data, w_strb);
        ADDR_GAIN_MAN: gain_man <= w_strb[0] ? w_data[7:0] : gain_man;
        ADDR_EXP_MIN:  exp_min <= wmerge(exp_min, w_data, w_strb);
        ADDR_EXP_MAX:  exp_max <= wmerge(exp_max, w_data, w_strb);
        ADDR_GAIN_MIN: gain_min <= w_strb[0] ? w_data[7:0] : gain_min;
        ADDR_GAIN_MAX: gain_max <= w_strb[0] ? w_data[7:0] : gain_max;
        ADDR_TARGET:   target <= {w_strb[1] ? w_data[15:8] : target[15:8],
                                  w_strb[0] ? w_data[7:0] : target[7:0]};
        ADDR_OFS_MAX:  ofs_max <= {w_strb[1] ? w_data[15:8] : ofs_max[15:8],
                                   w_strb[0] ? w_data[7:0] : ofs_max[7:0]};
        ADDR_TAP_OFS:  tap_ofs_last <= w_data;
        default:       ctrl <= ctrl;
      endcase
    end
  end

  // read channel: answer one cycle after the address is taken
  always_ff @(posedge clk_sys or negedge rst_q2) begin
    if (!rst_q2) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'b00;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= 2'b00;
        case (s_axi_araddr)
          ADDR_CTRL:     s_axi_rdata <= ctrl;
          ADDR_FPS:      s_axi_rdata <= fps;
          ADDR_EXP_MAN:  s_axi_rdata <= exp_man;
          ADDR_GAIN_MAN: s_axi_rdata <= {24'h0, gain_man};
          ADDR_EXP_MIN:  s_axi_rdata <= exp_min;
          ADDR_EXP_MAX:  s_axi_rdata <= exp_max;
          ADDR_GAIN_MIN: s_axi_rdata <= {24'h0, gain_min};
          ADDR_GAIN_MAX: s_axi_rdata <= {24'h0, gain_max};
          ADDR_TARGET:   s_axi_rdata <= {16'h0, target};
          ADDR_OFS_MAX:  s_axi_rdata <= {16'h0, ofs_max};
          ADDR_TAP_OFS:  s_axi_rdata <= tap_ofs_last;
          ADDR_PERIOD:   s_axi_rdata <= period_meas;
          ADDR_EXP_CUR:  s_axi_rdata <= exp_time;
          ADDR_GAIN_CUR: s_axi_rdata <= {24'h0, gain_db10};
          ADDR_AVG:      s_axi_rdata <= {16'h0, avg};
          ADDR_BLACK:    s_axi_rdata <= {16'h0, blk};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // phase accumulator: adds the rate each cycle, ticks on every clk_hz*100 crossed,
  // so the mean tick spacing is exactly the reciprocal without a divider
  always_ff @(posedge clk_sys or negedge rst_q2) begin
    if (!rst_q2) begin
      frame_acc   <= 34'h0;
      frame_tick  <= 1'b0;
      period_cnt  <= 32'h0;
      period_meas <= 32'h0;
    end else if (ce) begin
      frame_tick <= 1'b0;
      period_cnt <= period_cnt + 32'h1;
      if (frame_acc + {2'b00, fps} >= FRAME_ACC_LIMIT) begin
        frame_acc   <= frame_acc + {2'b00, fps} - FRAME_ACC_LIMIT;
        frame_tick  <= 1'b1;
        period_meas <= period_cnt + 32'h1;
        period_cnt  <= 32'h0;
      end else begin
        frame_acc <= frame_acc + {2'b00, fps};
      end
    end
  end

  // trigger pulse width in cycles, caught at the falling edge
  always_ff @(posedge clk_sys or negedge rst_q2) begin
    if (!rst_q2) begin
      trig_q     <= 1'b0;
      trig_cnt   <= 32'h0;
      trig_width <= EXP_RST;
    end else if (ce) begin
      trig_q <= trig_in;
      if (trig_in) begin
        trig_cnt <= trig_q ? trig_cnt + 32'h1 : 32'h1;
      end else if (trig_q) begin
        trig_width <= trig_cnt;
      end
    end
  end

  // line and column parity for the mosaic order
  always_ff @(posedge clk_sys or negedge rst_q2) begin
    if (!rst_q2) begin
      fv_q    <= 2'b00;
      lv_q    <= 1'b0;
      row_odd <= 1'b0;
      col_odd <= 1'b0;
    end else if (ce) begin
      fv_q <= {fv_q[0], sen_fval};
      lv_q <= sen_lval;
      if (!sen_fval) begin
        row_odd <= 1'b0;
      end else if (lv_q && !sen_lval) begin
        row_odd <= ~row_odd;
      end
      if (!sen_lval) begin
        col_odd <= 1'b0;
      end else if (sen_pix.vld && !sen_pix.dark) begin
        col_odd <= ~col_odd;
      end
    end
  end

  // stage one: hold the pixel while the tap offset is read
  always_ff @(posedge clk_sys or negedge rst_q2) begin
    if (!rst_q2) begin
      p1     <= '0;
      p1_cfa <= CFA_G;
      p1_act <= 1'b0;
    end else if (ce) begin
      p1     <= sen_pix;
      p1_act <= sen_pix.vld & ~sen_pix.dark & sen_fval & sen_lval;
      p1_cfa <= row_odd ? (col_odd ? CFA_G : CFA_B) : (col_odd ? CFA_R : CFA_G);
    end
  end

  egl_tap_mem #(
    .DEPTH (NTAPS),
    .WIDTH (16)
  ) u_tap_mem (
    .clk_sys (clk_sys),
    .ce      (ce),
    .we      (tap_we),
    .waddr   (w_data[TAP_SEL_LO +: TAP_W]),
    .wdata   (w_data[15:0]),
    .raddr   (sen_pix.tap),
    .rdata   (tap_rd)
  );

  // offset is black level plus the pixel's own tap trim, limited to the maximum
  assign ofs_sum = {1'b0, blk} + {1'b0, tap_rd};
  assign ofs_app = (ofs_sum > {1'b0, ofs_max}) ? ofs_max : ofs_sum[15:0];
  assign corr    = (p1.data > ofs_app) ? p1.data - ofs_app : 16'h0;

  // stage two: raw output, one value per pixel, no colour reconstruction
  always_ff @(posedge clk_sys or negedge rst_q2) begin
    if (!rst_q2) begin
      pix_out <= '0;
    end else if (ce) begin
      pix_out.vld <= p1_act;
      pix_out.tap <= p1.tap;
      pix_out.cfa <= p1_cfa;
      case (ctrl[CTRL_DEPTH_LO +: 2])
        DEPTH_8:  pix_out.data <= {8'h00, corr[15:8]};
        DEPTH_12: pix_out.data <= {4'h0, corr[15:4]};
        default:  pix_out.data <= corr;
      endcase
    end
  end

  // black level follows the dark pixels with a 1/16 leaky average
  always_ff @(posedge clk_sys or negedge rst_q2) begin
    if (!rst_q2) begin
      blk <= 16'h0;
    end else if (ce && p1.vld && p1.dark) begin
      blk <= 16'(17'(blk) + 17'($signed({1'b0, p1.data} - {1'b0, blk}) >>> BLK_SHIFT));
    end
  end

  // brightness sum over the active pixels of the frame
  always_ff @(posedge clk_sys or negedge rst_q2) begin
    if (!rst_q2) begin
      sum     <= 40'h0;
      pix_cnt <= 24'h0;
    end else if (ce) begin
      if (frame_start) begin
        sum     <= 40'h0;
        pix_cnt <= 24'h0;
      end else if (p1_act) begin
        sum     <= sum + {24'h0, corr};
        pix_cnt <= pix_cnt + 24'h1;
      end
    end
  end

  assign next_rem = {div_rem[23:0], div_num[39]};

  // luminance loop: divide for the mean, then move exposure or gain one step
  always_ff @(posedge clk_sys or negedge rst_q2) begin
    if (!rst_q2) begin
      ls        <= LS_IDLE;
      div_num   <= 40'h0;
      div_den   <= 24'h0;
      div_rem   <= 25'h0;
      div_step  <= 6'h0;
      avg       <= 16'h0;
      exp_pend  <= EXP_RST;
      gain_pend <= GAIN_RST;
    end else if (ce) begin
      case (ls)
        LS_IDLE: begin
          if (frame_end && pix_cnt != 24'h0) begin
            div_num  <= sum;
            div_den  <= pix_cnt;
            div_rem  <= 25'h0;
            div_step <= 6'd40;
            ls       <= LS_DIV;
          end
        end
        LS_DIV: begin
          // restoring division, one quotient bit per cycle
          if (next_rem >= {1'b0, div_den}) begin
            div_rem <= next_rem - {1'b0, div_den};
            div_num <= {div_num[38:0], 1'b1};
          end else begin
            div_rem <= next_rem;
            div_num <= {div_num[38:0], 1'b0};
          end
          div_step <= div_step - 6'h1;
          if (div_step == 6'h1) begin
            ls <= LS_ADJ;
          end
        end
        LS_ADJ: begin
          avg <= (|div_num[39:16]) ? 16'hFFFF : div_num[15:0];
          ls  <= LS_IDLE;
          if (ctrl[CTRL_AUTO]) begin
            // gain is the last resort since it also amplifies noise
            if (17'(div_num[15:0]) + 17'(LUMA_TOL) < 17'(target)) begin
              if (exp_pend < exp_max) begin
                exp_pend <= (exp_pend + (exp_pend >> EXP_SHIFT) + 32'h1 > exp_max) ?
                            exp_max : exp_pend + (exp_pend >> EXP_SHIFT) + 32'h1;
              end else if (gain_move(gain_pend, 1'b1, ctrl[CTRL_GAIN_STEP]) <= gain_max) begin
                gain_pend <= gain_move(gain_pend, 1'b1, ctrl[CTRL_GAIN_STEP]);
              end
            end else if (17'(div_num[15:0]) > 17'(target) + 17'(LUMA_TOL)) begin
              if (exp_pend > exp_min) begin
                exp_pend <= (exp_pend - (exp_pend >> EXP_SHIFT) - 32'h1 < exp_min) ?
                            exp_min : exp_pend - (exp_pend >> EXP_SHIFT) - 32'h1;
              end else if (gain_pend > gain_min &&
                           gain_move(gain_pend, 1'b0, ctrl[CTRL_GAIN_STEP]) >= gain_min) begin
                gain_pend <= gain_move(gain_pend, 1'b0, ctrl[CTRL_GAIN_STEP]);
              end
            end
          end else begin
            // loop restarts from the manual settings when enabled
            exp_pend  <= exp_man;
            gain_pend <= gain_man;
          end
        end
        default: ls <= LS_IDLE;
      endcase
    end
  end

  // settings reach the sensor only at a frame start, never mid-frame
  always_ff @(posedge clk_sys or negedge rst_q2) begin
    if (!rst_q2) begin
      exp_time  <= EXP_RST;
      gain_db10 <= GAIN_RST;
    end else if (ce && frame_start) begin
      if (ctrl[CTRL_AUTO]) begin
        exp_time  <= exp_pend;
        gain_db10 <= gain_pend;
      end else begin
        exp_time  <= ctrl[CTRL_EXP_SRC] ? trig_width : exp_man;
        gain_db10 <= gain_man;
      end
    end
  end
endmodule // egl_ctrl

// *** egl_chk.sv ***
`timescale 1ns/10ps
module egl_chk
  import egl_pkg::*;
(
  // clock and reset
  input wire logic         clk_sys,
  input wire logic         rstn,
  // sensor side
  input wire logic         sen_fval,
  input wire logic         sen_lval,
  input wire egl_pix_t     sen_pix,
  // settings and pixel output
  input wire logic [31:0]  exp_time,
  input wire logic [7:0]   gain_db10,
  input wire logic         frame_tick,
  input wire egl_pix_out_t pix_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // an input pixel that should reach the output
  wire act = sen_pix.vld & ~sen_pix.dark & sen_fval & sen_lval;
  a_exp_frame: assert property ($changed(exp_time) |-> $past(sen_fval) && !$past(sen_fval, 4))
    else $error("exposure moved away from a frame start");
  a_gain_frame: assert property ($changed(gain_db10) |-> $past(sen_fval) && !$past(sen_fval, 4))
    else $error("gain moved away from a frame start");
  a_pix_source: assert property (pix_out.vld |-> $past(act, 2))
    else $error("output pixel without an active input pixel");
  a_pix_latency: assert property (act |-> ##2 pix_out.vld)
    else $error("active pixel not delivered two cycles later");
  a_cfa_step: assert property (pix_out.vld && $past(pix_out.vld) && $past(pix_out.cfa) != CFA_G
    |-> pix_out.cfa == CFA_G)
    else $error("mosaic order broken within a line");
  a_tick_pulse: assert property (frame_tick |=> !frame_tick)
    else $error("frame tick longer than one cycle");
  a_gain_reset: assert property ($rose(rstn) |-> gain_db10 == GAIN_RST)
    else $error("gain not at 0 dB out of reset");
  a_pix_tap: assert property (pix_out.vld |-> pix_out.tap == $past(sen_pix.tap, 2))
    else $error("output pixel carries the wrong tap");
endmodule // egl_chk

bind egl_ctrl egl_chk egl_chk_i (.clk_sys, .rstn, .sen_fval, .sen_lval, .sen_pix, .exp_time,
  .gain_db10, .frame_tick, .pix_out);

// *** egl_sen_model.sv ***
`timescale 1ns/10ps
module egl_sen_model
  import egl_pkg::*;
(
  // clock and frame request
  input  wire logic        clk_sys,
  input  wire logic        go,
  input  wire logic [15:0] base,
  // sensor readout
  output logic             fval,
  output logic             lval,
  output egl_pix_t         pix
);
  // two lines, each one dark border pixel then eight active pixels
  initial begin
    fval = 0;
    lval = 0;
    pix = '0;
    forever begin
      @(posedge clk_sys);
      pix.data <= ~pix.data;  // idle data keeps moving so a stale value never looks valid
      if (go) begin
        fval <= 1;
        for (int r = 0; r < 2; r++) begin
          repeat (3) @(posedge clk_sys);
          lval <= 1;
          for (int c = 0; c < 9; c++) begin
            pix <= '{1'b1, c == 0, 2'(c), c ? base + 16'(c) : 16'h0};
            @(posedge clk_sys);
          end
          lval <= 0;
          pix.vld <= 0;
        end
        repeat (2) @(posedge clk_sys);
        fval <= 0;
      end
    end
  end
endmodule // egl_sen_model

// *** egl_ctrl_bench.sv ***
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; $display("BAD %0t %h %h", $time, a, e); end end
module egl_ctrl_bench
  import egl_pkg::*;
;
  // bench drive and observed outputs
  logic        clk_sys = 0, rstn = 0, ce = 1, trig_in = 0, go = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, gain_db10;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, exp_time, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic        s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, sen_fval, sen_lval, frame_tick;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic [15:0] base = 0;
  egl_pix_t     sen_pix;
  egl_pix_out_t pix_out;
  int fails = 0, total_checks = 0, cyc = 0, rs = 41, omax = 'hFFF, sh = 8, e, g, pe;
  int ofs[4] = '{0, 0, 0, 0};
  int q[$];  // expected {tap, colour, data} of each active pixel
  wire [19:0] pw = {pix_out.tap, pix_out.cfa, pix_out.data};
  egl_ctrl egl_ctrl_i (.*);
  egl_sen_model egl_sen_model_i (.clk_sys, .go, .base, .fval(sen_fval), .lval(sen_lval),
    .pix(sen_pix));
  initial forever #10 clk_sys = ~clk_sys;
  // hang guard, under twice the expected run
  always @(posedge clk_sys) if (++cyc == 12000) begin
    fails++;
    final_report();
  end
  // every delivered pixel is popped against the model
  always @(posedge clk_sys) if (pix_out.vld === 1) begin
    pe = q.pop_front();
    `CHK(pw, 20'(pe))
  end
  task automatic final_report();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic int xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1);
    rr = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  // one frame: expected pixels queued, then the sensor is started
  task automatic frame();
    logic [15:0] b;
    int d, o, s;
    b = 16'(xs()) & 16'h7FFF;
    base <= b;
    s = 0;
    for (int r = 0; r < 2; r++) for (int c = 1; c < 9; c++) begin
      o = ofs[c % 4] < omax ? ofs[c % 4] : omax;
      d = b + c > o ? b + c - o : 0;
      s += d;
      q.push_back({2'(c), r ? (c % 2 ? CFA_B : CFA_G) : (c % 2 ? CFA_G : CFA_R), 16'(d >> sh)});
    end
    @(posedge clk_sys);
    go <= 1;
    @(posedge clk_sys);
    go <= 0;
    repeat (100) @(posedge clk_sys);
    `CHK(q.size(), 0)
    rd_reg(ADDR_AVG);
    `CHK(rd, 32'(s / 16))
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    rstn <= 1;
    repeat (3) @(posedge clk_sys);
    rd_reg(ADDR_GAIN_CUR);
    `CHK(rd, 32'h0)
    rd_reg(8'h40);
    `CHK({rr, rd}, 34'h2_0000_0000)
    wr(ADDR_PERIOD, 32'h0);
    `CHK(rr, 2'h2)
    wr(ADDR_FPS, 32'h004C_4B40);
    repeat (2200) @(posedge clk_sys);
    rd_reg(ADDR_PERIOD);
    `CHK(rd, 32'h0000_03E8)
    // start right after a tick so the window holds exactly two more
    @(posedge clk_sys iff frame_tick === 1);
    e = 0;
    repeat (2500) begin
      @(posedge clk_sys);
      if (frame_tick === 1) e++;
    end
    `CHK(e, 2)
    $display("register and rate test done");
    wr(ADDR_OFS_MAX, 32'h0000_0040);
    wr(ADDR_TAP_OFS, 32'h0001_0010);
    wr(ADDR_TAP_OFS, 32'h0002_0080);
    // trim memory has no reset, so the unused taps get a known zero
    wr(ADDR_TAP_OFS, 32'h0000_0000);
    wr(ADDR_TAP_OFS, 32'h0003_0000);
    omax = 'h40;
    ofs[1] = 'h10;
    ofs[2] = 'h80;  // above the clamp on purpose
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTRL, 32'(i) << CTRL_DEPTH_LO);
      sh = 8 - 4 * i;
      frame();
    end
    $display("pixel test done");
    wr(ADDR_CTRL, 32'h0000_000A);
    trig_in <= 1;
    repeat (100) @(posedge clk_sys);
    trig_in <= 0;
    frame();
    `CHK(exp_time, 32'h0000_0064)
    wr(ADDR_CTRL, 32'h0000_0008);
    frame();
    `CHK(exp_time, EXP_RST)
    $display("exposure source test done");
    wr(ADDR_EXP_MAX, 32'h0000_6000);
    wr(ADDR_TARGET, 32'h0000_FFFF);
    wr(ADDR_CTRL, 32'h0000_0019);
    e = EXP_RST;
    g = 0;
    repeat (6) begin
      frame();
      `CHK(exp_time, 32'(e))
      `CHK(gain_db10, GAIN_STEP_TAB[g])
      if (e == 'h6000) g++;
      else e = e + e / 8 + 1 > 'h6000 ? 'h6000 : e + e / 8 + 1;
    end
    $display("auto luminance test done");
    final_report();
  end
endmodule // egl_ctrl_bench
